// ===== hdl/eic2_regbank.sv
// second extended control and interrupt register with suspend sequencing
// assumes event inputs are synchronous pulses; phy_detected is a pin and is synchronised
//
// Notes on behaviour
// - writing back read value clears seen flags
// - quick suspend finishes active work, starts none
// - slow suspend drains all queued packets first
// - suspend method taken from same write's bit
// - quick suspend clears on any reset or stop
// - frame tag output gated by address detect select
// - demand triggers immediate ring access if receiver on and new work allowed
// - demand set by one, cleared by fetch
// - poll disable stops automatic descriptor polling
// - timer zero sets flag and reloads value
// - flags gated by enables; enables hard reset
// - flags write-one-clear, hard reset only
// - turnaround not low sets read error flag
// - autopoll mismatch flag, method change suppresses first
// - host port access done sets flag
// - host done enable covers host accesses only
// - internal frame done sets internal flag
// - phy detect either edge sets flag
// - reserved upper bits read as zero
`timescale 1ns/1ps
`default_nettype none
`include "eci2_cfg.svh"
module eic2_regbank
  import eic2_pkg::*;
#(
  parameter int TIMER_W = `EIC2_TMR_W
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic soft_rst_i,
  input wire logic stop_i,
  input wire logic [`EIC2_ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic receiver_on_i,
  input wire logic external_address_detect_select_i,
  input wire logic desc_fetched_i,
  input wire logic poll_tick_i,
  input wire logic tx_active_i,
  input wire logic rx_active_i,
  input wire logic dma_active_i,
  input wire logic tx_queued_i,
  input wire logic rx_queued_i,
  input wire logic mgmt_turnaround_high_i,
  input wire logic host_cmd_done_i,
  input wire logic internal_cmd_done_i,
  input wire logic autopoll_frame_done_i,
  input wire logic autopoll_mismatch_i,
  input wire logic autopoll_method_change_i,
  input wire logic phy_detected_i,
  output logic rx_ring_access_o,
  output logic rx_frame_tag_o,
  output logic new_work_allowed_o,
  output logic drain_queues_o,
  output logic suspended_o,
  output logic combined_interrupt_bit_o,
  output logic interrupt_pin_o
);

  // reload field must fit the low half of the read word
  if (TIMER_W < 1 || TIMER_W > 16) begin : g_bad_timer_w
    $error("TIMER_W out of range");
  end

  function automatic logic w1(input int b);
    return wr_i && addr_i == `EIC2_OFF_MAIN && wdata_i[b];
  endfunction : w1

  function automatic logic flag_nx(input logic cur, input logic set, input logic clr);
    return set | (cur & ~clr);
  endfunction : flag_nx

  logic quick_suspend_enable_q;
  logic rx_frame_tag_enable_q;
  logic rx_ring_demand_q;
  logic rx_poll_disable_q;
  logic [5:0] enables_q;
  logic soft_timer_irq_flag_q;
  logic mgmt_read_error_flag_q;
  logic autopoll_change_flag_q;
  logic host_cmd_done_flag_q;
  logic internal_cmd_done_flag_q;
  logic phy_detect_change_flag_q;
  logic [5:0] flags;
  logic [TIMER_W-1:0] soft_timer_reload_value_q;
  logic [TIMER_W-1:0] timer_q;
  logic suspend_request_q;
  logic quick_latched_q;
  eic2_susp_t sp_q;
  logic pd_s1_q;
  logic pd_s2_q;
  logic pd_prev_q;
  logic ap_first_q;
  logic [5:0] ev;
  logic [5:0] clr;
  logic timer_zero;
  logic wr_main;

  assign wr_main = wr_i && addr_i == `EIC2_OFF_MAIN;
  assign timer_zero = timer_q == '0;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || soft_rst_i || stop_i) begin
      quick_suspend_enable_q <= 1'b0;
    end else if (wr_main) begin
      quick_suspend_enable_q <= wdata_i[`EIC2_B_QSPND];
    end
  end

  // tag enable survives soft reset and stop
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rx_frame_tag_enable_q <= 1'b0;
    end else if (wr_main) begin
      rx_frame_tag_enable_q <= wdata_i[`EIC2_B_RXTAG];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rx_poll_disable_q <= 1'b0;
    end else if (wr_main) begin
      rx_poll_disable_q <= wdata_i[`EIC2_B_RXPDIS];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      enables_q <= '0;
    end else if (wr_main) begin
      enables_q <= {wdata_i[`EIC2_B_TMRE], wdata_i[`EIC2_B_MREE], wdata_i[`EIC2_B_APE],
                    wdata_i[`EIC2_B_HCE], wdata_i[`EIC2_B_ICE], wdata_i[`EIC2_B_PDE]};
    end
  end

  // demand: set wins over fetch clear
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rx_ring_demand_q <= 1'b0;
    end else begin
      rx_ring_demand_q <= flag_nx(rx_ring_demand_q, w1(`EIC2_B_RXDMD), desc_fetched_i);
    end
  end

  // ring access request: demand immediate, poll tick only when polling enabled
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rx_ring_access_o <= 1'b0;
    end else begin
      rx_ring_access_o <= receiver_on_i && new_work_allowed_o &&
                          (rx_ring_demand_q || (poll_tick_i && !rx_poll_disable_q));
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rx_frame_tag_o <= 1'b0;
    end else begin
      rx_frame_tag_o <= rx_frame_tag_enable_q && external_address_detect_select_i;
    end
  end

  // software timer
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      soft_timer_reload_value_q <= TIMER_W'(`EIC2_TMR_RST);
      timer_q <= TIMER_W'(`EIC2_TMR_RST);
    end else begin
      if (wr_i && addr_i == `EIC2_OFF_TIMER) begin
        soft_timer_reload_value_q <= wdata_i[TIMER_W-1:0];
      end
      if (timer_zero) begin
        timer_q <= soft_timer_reload_value_q;
      end else begin
        timer_q <= timer_q - 1'b1;
      end
    end
  end

  // phy detect synchroniser and edge
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pd_s1_q <= 1'b0;
      pd_s2_q <= 1'b0;
      pd_prev_q <= 1'b0;
    end else begin
      pd_s1_q <= phy_detected_i;
      pd_s2_q <= pd_s1_q;
      pd_prev_q <= pd_s2_q;
    end
  end

  // first autopoll compare after a method change is not reported
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ap_first_q <= 1'b1;
    end else if (autopoll_method_change_i) begin
      ap_first_q <= 1'b1;
    end else if (autopoll_frame_done_i) begin
      ap_first_q <= 1'b0;
    end
  end

  // flag order: timer, read err, autopoll, host done, internal done, phy detect
  always_comb begin
    ev[5] = timer_zero;
    ev[4] = mgmt_turnaround_high_i;
    ev[3] = autopoll_frame_done_i && autopoll_mismatch_i && !ap_first_q &&
            !autopoll_method_change_i;
    ev[2] = host_cmd_done_i;
    ev[1] = internal_cmd_done_i || autopoll_frame_done_i;
    ev[0] = pd_s2_q ^ pd_prev_q;
    clr = {w1(`EIC2_B_TMRF), w1(`EIC2_B_MREF), w1(`EIC2_B_APF),
           w1(`EIC2_B_HCF), w1(`EIC2_B_ICF), w1(`EIC2_B_PDF)};
  end

  // flags: hard reset only, set wins over a same-cycle clear
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      soft_timer_irq_flag_q <= 1'b0;
    end else begin
      soft_timer_irq_flag_q <= flag_nx(soft_timer_irq_flag_q, ev[5], clr[5]);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      mgmt_read_error_flag_q <= 1'b0;
    end else begin
      mgmt_read_error_flag_q <= flag_nx(mgmt_read_error_flag_q, ev[4], clr[4]);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      autopoll_change_flag_q <= 1'b0;
    end else begin
      autopoll_change_flag_q <= flag_nx(autopoll_change_flag_q, ev[3], clr[3]);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      host_cmd_done_flag_q <= 1'b0;
    end else begin
      host_cmd_done_flag_q <= flag_nx(host_cmd_done_flag_q, ev[2], clr[2]);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      internal_cmd_done_flag_q <= 1'b0;
    end else begin
      internal_cmd_done_flag_q <= flag_nx(internal_cmd_done_flag_q, ev[1], clr[1]);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      phy_detect_change_flag_q <= 1'b0;
    end else begin
      phy_detect_change_flag_q <= flag_nx(phy_detect_change_flag_q, ev[0], clr[0]);
    end
  end

  assign flags = {soft_timer_irq_flag_q, mgmt_read_error_flag_q, autopoll_change_flag_q,
                  host_cmd_done_flag_q, internal_cmd_done_flag_q, phy_detect_change_flag_q};

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      combined_interrupt_bit_o <= 1'b0;
    end else begin
      combined_interrupt_bit_o <= |(flags & enables_q);
    end
  end

  // pin mirrors the combined bit; no global enable in this block
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      interrupt_pin_o <= 1'b0;
    end else begin
      interrupt_pin_o <= |(flags & enables_q);
    end
  end

  // suspend sequencing; request written at a separate offset
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || soft_rst_i || stop_i) begin
      suspend_request_q <= 1'b0;
      quick_latched_q <= 1'b0;
      sp_q <= EIC2_SP_RUN;
    end else begin
      if (wr_i && addr_i == `EIC2_OFF_STAT) begin
        suspend_request_q <= wdata_i[0];
        if (wdata_i[0]) begin
          quick_latched_q <= wdata_i[`EIC2_B_QSPND];
        end
      end
      case (sp_q)
        EIC2_SP_RUN: begin
          if (suspend_request_q) begin
            sp_q <= EIC2_SP_DRAIN;
          end
        end
        EIC2_SP_DRAIN: begin
          if (!suspend_request_q) begin
            sp_q <= EIC2_SP_RUN;
          end else if (!tx_active_i && !rx_active_i && !dma_active_i &&
                       (quick_latched_q || (!tx_queued_i && !rx_queued_i))) begin
            sp_q <= EIC2_SP_SUSP;
          end
        end
        EIC2_SP_SUSP: begin
          if (!suspend_request_q) begin
            sp_q <= EIC2_SP_RUN;
          end
        end
        default: sp_q <= EIC2_SP_RUN;
      endcase
    end
  end

  // new work stops as soon as the request is seen
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      new_work_allowed_o <= 1'b1;
    end else begin
      new_work_allowed_o <= sp_q == EIC2_SP_RUN && !suspend_request_q;
    end
  end

  // flush only on the slow method
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      drain_queues_o <= 1'b0;
    end else begin
      drain_queues_o <= sp_q == EIC2_SP_DRAIN && !quick_latched_q;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      suspended_o <= 1'b0;
    end else begin
      suspended_o <= sp_q == EIC2_SP_SUSP;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      case (addr_i)
        `EIC2_OFF_MAIN: rdata_o <= {16'h0000, quick_suspend_enable_q, rx_frame_tag_enable_q,
                                    rx_ring_demand_q, rx_poll_disable_q,
                                    flags[5], enables_q[5], flags[4], enables_q[4],
                                    flags[3], enables_q[3], flags[2], enables_q[2],
                                    flags[1], enables_q[1], flags[0], enables_q[0]};
        `EIC2_OFF_STAT: rdata_o <= {30'h0, quick_latched_q, sp_q == EIC2_SP_SUSP};
        `EIC2_OFF_TIMER: rdata_o <= 32'(soft_timer_reload_value_q);
        default: rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end

endmodule : eic2_regbank
`default_nettype wire

// ===== hdl/eci2_cfg.svh
// field positions, offsets and reset values for the second extended control/irq register
// assumes inclusion by the package and the register bank only
`ifndef EIC2_CFG_SVH
`define EIC2_CFG_SVH
`define EIC2_ADDR_W 4
`define EIC2_OFF_MAIN 4'h0
`define EIC2_OFF_STAT 4'h1
`define EIC2_OFF_TIMER 4'h2
`define EIC2_B_QSPND 15
`define EIC2_B_RXTAG 14
`define EIC2_B_RXDMD 13
`define EIC2_B_RXPDIS 12
`define EIC2_B_TMRF 11
`define EIC2_B_TMRE 10
`define EIC2_B_MREF 9
`define EIC2_B_MREE 8
`define EIC2_B_APF 7
`define EIC2_B_APE 6
`define EIC2_B_HCF 5
`define EIC2_B_HCE 4
`define EIC2_B_ICF 3
`define EIC2_B_ICE 2
`define EIC2_B_PDF 1
`define EIC2_B_PDE 0
`define EIC2_TMR_W 6
`define EIC2_TMR_RST 6'h3f
`endif

// ===== hdl/eic2_pkg.sv
// types shared by the extended control/irq register bank
// assumes the cfg header sits beside it
`include "eci2_cfg.svh"
package eic2_pkg;
  typedef enum logic [1:0] {
    EIC2_SP_RUN,
    EIC2_SP_DRAIN,
    EIC2_SP_SUSP
  } eic2_susp_t;
endpackage : eic2_pkg

// ===== verif/eic2_regbank_props.sv
// port-level checks for the extended control/irq register bank
// assumes binding onto eic2_regbank; reset synchronous active low
`timescale 1ns/1ps
`default_nettype none
module eic2_props (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic stop_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic receiver_on_i,
  input wire logic rx_ring_access_o,
  input wire logic new_work_allowed_o,
  input wire logic suspended_o,
  input wire logic combined_interrupt_bit_o,
  input wire logic interrupt_pin_o
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  chk_resv_zero: assert property ($past(rd_i) |-> rdata_o[31:16] == 16'h0)
    else $error("reserved bits not zero");
  chk_unmap_zero: assert property ($past(rd_i) && $past(addr_i) > 4'h2 |-> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  chk_pin_comb: assert property (interrupt_pin_o == combined_interrupt_bit_o)
    else $error("pin and combined differ");
  chk_ring_receiver_on: assert property (rx_ring_access_o |-> $past(receiver_on_i))
    else $error("ring access with receiver off");
  chk_demand_acc: assert property (wr_i && addr_i == 4'h0 && wdata_i[13] && receiver_on_i
    && new_work_allowed_o |-> ##[1:3] rx_ring_access_o)
    else $error("demand gave no ring access");
  chk_susp_nowork: assert property (suspended_o |-> !new_work_allowed_o)
    else $error("new work while suspended");
  chk_stop_exit: assert property (stop_i |-> ##2 !suspended_o)
    else $error("stop kept suspend");
  chk_rst_quiet: assert property ($rose(rst_n_i) |-> !combined_interrupt_bit_o && new_work_allowed_o)
    else $error("bad state after reset");
  cover property ($rose(suspended_o));
  cover property ($rose(combined_interrupt_bit_o));
  cover property (rx_ring_access_o);
endmodule : eic2_props
bind eic2_regbank eic2_props u_props (.ref_clk_i, .rst_n_i, .stop_i, .addr_i, .wdata_i,
  .wr_i, .rd_i, .rdata_o, .receiver_on_i, .rx_ring_access_o, .new_work_allowed_o,
  .suspended_o, .combined_interrupt_bit_o, .interrupt_pin_o);
`default_nettype wire

// ===== verif/tb.sv
// bench: drives the register bank ports and compares with an int model
// assumes design files and checker compiled before it
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk_i='0,rst_n_i='0,soft_rst_i='0,stop_i='0,wr_i='0,rd_i='0,tx_queued_i='0;
  logic receiver_on_i='0,external_address_detect_select_i='0,phy_detected_i='0;
  logic autopoll_mismatch_i='0,rx_ring_access_o,rx_frame_tag_o,new_work_allowed_o;
  logic drain_queues_o,suspended_o,combined_interrupt_bit_o,interrupt_pin_o;
  logic [6:0] p=7'h0;
  logic [3:0] addr_i=4'h0;
  logic [31:0] wdata_i=32'h0,rdata_o,r;
  int failures=0,checked=0,seed=14963,m=0,acc=0,i,k,fb[4]='{9,5,3,1};
  always #20 ref_clk_i=~ref_clk_i;
  always @(posedge ref_clk_i) if (rx_ring_access_o===1'b1) acc++;
  eic2_regbank u_dut (.ref_clk_i,.rst_n_i,.soft_rst_i,.stop_i,.addr_i,.wdata_i,.wr_i,
    .rd_i,.rdata_o,.receiver_on_i,.external_address_detect_select_i,.desc_fetched_i(p[3]),
    .poll_tick_i(p[4]),.tx_active_i(1'b0),.rx_active_i(1'b0),.dma_active_i(1'b0),
    .tx_queued_i,.rx_queued_i(1'b0),.mgmt_turnaround_high_i(p[0]),.host_cmd_done_i(p[1]),
    .internal_cmd_done_i(p[2]),.autopoll_frame_done_i(p[5]),.autopoll_mismatch_i,
    .autopoll_method_change_i(p[6]),.phy_detected_i,.rx_ring_access_o,.rx_frame_tag_o,
    .new_work_allowed_o,.drain_queues_o,.suspended_o,.combined_interrupt_bit_o,
    .interrupt_pin_o);
  task automatic finish_test;
    if (failures==0 && checked>0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  task automatic chk(logic [31:0] e, logic [31:0] g);
    checked++;
    if (g!==e) begin
      failures++;
      $display("ERROR t=%0t exp=%h got=%h",$time,e,g);
    end
  endtask : chk
  task automatic cy(int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : cy
  // model: ctrl and enables plain, demand set-only, flags write-one-clear
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i<=a;
    wdata_i<=d;
    wr_i<=1'b1;
    @(posedge ref_clk_i);
    wr_i<=1'b0;
    if (a==4'h0) m=((m&~32'hd555)|(d&32'hf555))&~(d&32'h2aa);
  endtask : wr
  task automatic rd(logic [3:0] a);
    @(posedge ref_clk_i);
    addr_i<=a;
    rd_i<=1'b1;
    @(posedge ref_clk_i);
    rd_i<=1'b0;
    #1 r=rdata_o;
  endtask : rd
  // timer flag masked out of the main register compare
  task automatic cm;
    rd(4'h0);
    chk(m,r&32'hf7ff);
    chk(((m>>1)&m&32'h155)!=0,combined_interrupt_bit_o);
    chk(((m>>1)&m&32'h155)!=0,interrupt_pin_o);
  endtask : cm
  task automatic ev(int j);
    @(posedge ref_clk_i);
    if (j>6) phy_detected_i<=~phy_detected_i;
    else p<=7'h1<<j;
    @(posedge ref_clk_i);
    p<=7'h0;
    cy(5);
  endtask : ev
  task automatic ps(logic [3:0] a, int b);
    for (i=0; i<60; i++) begin
      rd(a);
      if (r[b]===1'b1) return;
    end
    failures++;
    finish_test;
  endtask : ps
  initial begin
    cy(4);
    rst_n_i<=1'b1;
    rd(4'h0);
    chk(0,r);
    rd(4'h2);
    chk(32'h3f,r);
    wr(4'h9,32'hffff);
    rd(4'h9);
    chk(0,r);
    for (k=0; k<4; k++) begin
      ev(k==3 ? 7 : k);
      m|=32'h1<<fb[k];
      cm;
      wr(4'h0,32'h1<<(fb[k]-1));
      cm;
      wr(4'h0,32'h1<<(fb[k]-1));
      cm;
      wr(4'h0,32'h3<<(fb[k]-1));
      cm;
    end
    autopoll_mismatch_i<=1'b1;
    wr(4'h0,32'h10);
    ev(5);
    m|=32'h8;
    cm;
    ev(5);
    m|=32'h88;
    cm;
    wr(4'h0,32'haa);
    ev(6);
    ev(5);
    m|=32'h8;
    cm;
    receiver_on_i<=1'b1;
    wr(4'h0,32'h2000);
    wr(4'h0,32'h0);
    cm;
    ev(3);
    m&=~32'h2000;
    cm;
    wr(4'h0,32'h1000);
    acc=0;
    ev(4);
    chk(0,acc);
    wr(4'h0,32'h0);
    acc=0;
    ev(4);
    chk(1,acc!=0);
    receiver_on_i<=1'b0;
    acc=0;
    ev(4);
    chk(0,acc);
    receiver_on_i<=1'b1;
    external_address_detect_select_i<=1'b1;
    wr(4'h0,32'hc000);
    cy(2);
    chk(1,rx_frame_tag_o);
    external_address_detect_select_i<=1'b0;
    cy(2);
    chk(0,rx_frame_tag_o);
    soft_rst_i<=1'b1;
    cy(1);
    soft_rst_i<=1'b0;
    m&=~32'h8000;
    cm;
    tx_queued_i<=1'b1;
    wr(4'h1,32'h8001);
    ps(4'h1,0);
    chk(3,r);
    chk(1,suspended_o);
    chk(0,new_work_allowed_o);
    stop_i<=1'b1;
    cy(2);
    stop_i<=1'b0;
    rd(4'h1);
    chk(0,r[0]);
    wr(4'h1,32'h1);
    cy(8);
    rd(4'h1);
    chk(0,r);
    chk(1,drain_queues_o);
    tx_queued_i<=1'b0;
    ps(4'h1,0);
    chk(1,r);
    wr(4'h1,32'h0);
    for (k=0; k<8; k++) begin
      wr(4'h0,$random(seed)&32'hf3ff);
      cm;
    end
    wr(4'h0,32'hc00);
    ps(4'h0,11);
    chk(1,combined_interrupt_bit_o);
    wr(4'h0,r);
    rd(4'h0);
    chk(0,r&32'h800);
    finish_test;
  end
endmodule : tb
`default_nettype wire
